// ===== design/user_break_match_unit.sv
// Two-channel user break unit with AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "user_break_consts.svh"
module user_break_match_unit
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // AXI4-Lite register port
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Confirmed instruction from the pipeline
  input wire logic insnValid,
  input wire logic [31:0] insnAddr,
  input wire logic [7:0] insnSpace,
  input wire logic insnDelaySlot,
  input wire logic insnDelayedBranch,
  input wire logic [31:0] insnBranchAddr,
  // Data access cycle
  input wire logic cycValid,
  input wire logic [31:0] cycAddr,
  input wire logic [7:0] cycSpace,
  input wire logic cycWrite,
  input wire logic [1:0] cycSize,
  input wire logic [31:0] cycData,
  // Exception logic
  output logic insnGrant,
  output logic breakReq,
  output logic [31:0] breakPc,
  input wire logic breakAck
);
  logic wrEn;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrErr;
  logic [7:0] rdAddr;
  logic [31:0] rdData;
  logic rdErr;
  logic [31:0] wrMerged;
  logic [31:0] rdOld;

  logic [31:0] aAddr_q;
  logic [7:0] aSpace_q;
  logic [2:0] aMask_q;
  logic [5:0] aCond_q;
  logic [31:0] bAddr_q;
  logic [7:0] bSpace_q;
  logic [2:0] bMask_q;
  logic [5:0] bCond_q;
  logic [31:0] bData_q;
  logic [31:0] bDataMask_q;
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic aSeen_q;
  logic pendAfter_q;
  logic pendSkip_q;
  logic pendUseBr_q;
  logic [31:0] pendPc_q;

  logic insnLive;
  logic aFetch;
  logic aData;
  logic bFetch;
  logic bData;
  logic ordered;
  logic bFetchCnt;
  logic bDataCnt;
  logic trigBefore;
  logic trigAfter;
  logic trigData;
  logic pendFires;

  axil_reg_port u_port
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrErr(wrErr),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdErr(rdErr)
  );

  // Read decode on the read address; the byte-lane merge has its own decode below
  // reserved bits read zero
  always_comb
  begin
    rdData = 32'h0000_0000;
    rdErr = 1'b0;
    unique case (rdAddr)
      `UB_OFS_A_ADDR: rdData = aAddr_q;
      `UB_OFS_A_SPACE: rdData = {24'h000000, aSpace_q};
      `UB_OFS_A_MASK: rdData = {29'h00000000, aMask_q};
      `UB_OFS_A_COND: rdData = {26'h0000000, aCond_q};
      `UB_OFS_B_ADDR: rdData = bAddr_q;
      `UB_OFS_B_SPACE: rdData = {24'h000000, bSpace_q};
      `UB_OFS_B_MASK: rdData = {29'h00000000, bMask_q};
      `UB_OFS_B_COND: rdData = {26'h0000000, bCond_q};
      `UB_OFS_B_DATA: rdData = bData_q;
      `UB_OFS_B_DMASK: rdData = bDataMask_q;
      `UB_OFS_CTRL: rdData = {16'h0000, ctrl_q};
      `UB_OFS_STATE: rdData = {29'h00000000, pendAfter_q, breakReq, aSeen_q};
      default: rdErr = 1'b1;
    endcase
  end

  // Old contents of the word being written; the space, mask and cond registers give zero
  always_comb
  begin
    rdOld = 32'h0000_0000;
    wrErr = 1'b0;
    unique case (wrAddr)
      `UB_OFS_A_ADDR: rdOld = aAddr_q;
      `UB_OFS_B_ADDR: rdOld = bAddr_q;
      `UB_OFS_B_DATA: rdOld = bData_q;
      `UB_OFS_B_DMASK: rdOld = bDataMask_q;
      `UB_OFS_CTRL: rdOld = {16'h0000, ctrl_q};
      `UB_OFS_A_SPACE, `UB_OFS_A_MASK, `UB_OFS_A_COND: rdOld = 32'h0000_0000;
      `UB_OFS_B_SPACE, `UB_OFS_B_MASK, `UB_OFS_B_COND: rdOld = 32'h0000_0000;
      `UB_OFS_STATE: rdOld = 32'h0000_0000;
      default: wrErr = 1'b1;
    endcase
  end

  // Byte strobes pick new lanes; others keep their value, or go to zero in the space, mask and cond registers
  for (genvar i = 0; i < 4; i++)
  begin : g_lane
    assign wrMerged[8*i+7:8*i] = wrStrb[i] ? wrData[8*i+7:8*i] : rdOld[8*i+7:8*i];
  end

  // Condition registers; cycle conditions cleared by reset
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      aAddr_q <= `UB_WORD_RESET;
      aSpace_q <= 8'h00;
      aMask_q <= 3'h0;
      aCond_q <= `UB_COND_RESET;
      bAddr_q <= `UB_WORD_RESET;
      bSpace_q <= 8'h00;
      bMask_q <= 3'h0;
      bCond_q <= `UB_COND_RESET;
      bData_q <= `UB_WORD_RESET;
      bDataMask_q <= `UB_WORD_RESET;
    end
    else if (wrEn)
    begin
      unique case (wrAddr)
        `UB_OFS_A_ADDR: aAddr_q <= wrMerged;
        `UB_OFS_A_SPACE: aSpace_q <= wrMerged[7:0];
        `UB_OFS_A_MASK: aMask_q <= wrMerged[2:0];
        `UB_OFS_A_COND: aCond_q <= wrMerged[5:0];
        `UB_OFS_B_ADDR: bAddr_q <= wrMerged;
        `UB_OFS_B_SPACE: bSpace_q <= wrMerged[7:0];
        `UB_OFS_B_MASK: bMask_q <= wrMerged[2:0];
        `UB_OFS_B_COND: bCond_q <= wrMerged[5:0];
        `UB_OFS_B_DATA: bData_q <= wrMerged;
        `UB_OFS_B_DMASK: bDataMask_q <= wrMerged;
        default: ;
      endcase
    end
  end

  // Channel comparators; channel A has no data compare
  assign insnLive = insnValid && !breakReq;
  break_chan_match u_chan_a
  (
    .cfgAddr(aAddr_q),
    .cfgSpace(aSpace_q),
    .cfgMask(aMask_q),
    .cfgCond(aCond_q),
    .cfgDataEn(1'b0),
    .cfgData(32'h0000_0000),
    .cfgDataMask(32'h0000_0000),
    .insnValid(insnLive),
    .insnAddr(insnAddr),
    .insnSpace(insnSpace),
    .cycValid(cycValid),
    .cycAddr(cycAddr),
    .cycSpace(cycSpace),
    .cycWrite(cycWrite),
    .cycSize(cycSize),
    .cycData(cycData),
    .fetchHit(aFetch),
    .dataHit(aData)
  );

  break_chan_match u_chan_b
  (
    .cfgAddr(bAddr_q),
    .cfgSpace(bSpace_q),
    .cfgMask(bMask_q),
    .cfgCond(bCond_q),
    .cfgDataEn(ctrl_q[`UB_CTRL_DATA_EN]),
    .cfgData(bData_q),
    .cfgDataMask(bDataMask_q),
    .insnValid(insnLive),
    .insnAddr(insnAddr),
    .insnSpace(insnSpace),
    .cycValid(cycValid),
    .cycAddr(cycAddr),
    .cycSpace(cycSpace),
    .cycWrite(cycWrite),
    .cycSize(cycSize),
    .cycData(cycData),
    .fetchHit(bFetch),
    .dataHit(bData)
  );

  // In ordered mode B counts only after a registered A match
  // simultaneous A and B does not count
  assign ordered = ctrl_q[`UB_CTRL_ORDERED];
  assign bFetchCnt = bFetch && (!ordered || aSeen_q);
  assign bDataCnt = bData && (!ordered || aSeen_q);

  assign trigBefore = (!ordered && aFetch && !ctrl_q[`UB_CTRL_AFTER_A])
    || (bFetchCnt && !ctrl_q[`UB_CTRL_AFTER_B]);
  assign trigAfter = (!ordered && aFetch && ctrl_q[`UB_CTRL_AFTER_A])
    || (bFetchCnt && ctrl_q[`UB_CTRL_AFTER_B]);
  assign trigData = (!ordered && aData) || bDataCnt;
  assign pendFires = pendAfter_q && !(pendSkip_q && insnDelaySlot);

  // Ordered mode history; cleared once the sequence completes
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      aSeen_q <= 1'b0;
    else if (!ordered)
      aSeen_q <= 1'b0;
    else if (bFetchCnt || bDataCnt)
      aSeen_q <= 1'b0;
    else if (aFetch || aData)
      aSeen_q <= 1'b1;
  end

  // set wins over a software clear
  // ordered mode sets only flag B
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wrEn && wrAddr == `UB_OFS_CTRL)
      ctrl_d = wrMerged[15:0] & `UB_CTRL_WMASK & (ctrl_q | 16'h3fff);
    if (!ordered && (aFetch || aData))
      ctrl_d[`UB_CTRL_FLAG_A] = 1'b1;
    if (bFetchCnt || bDataCnt)
      ctrl_d[`UB_CTRL_FLAG_B] = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      ctrl_q <= `UB_CTRL_RESET;
    else
      ctrl_q <= ctrl_d;
  end

  // Deferred trap waiting for the next executed instruction
  // slot of a delayed branch runs before the trap
  // data match traps before the following instruction
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pendAfter_q <= 1'b0;
      pendSkip_q <= 1'b0;
      pendUseBr_q <= 1'b0;
      pendPc_q <= 32'h0000_0000;
    end
    else
    begin
      if (insnLive)
      begin
        if (trigBefore || pendFires)
          pendAfter_q <= 1'b0;
        else if (trigAfter)
        begin
          pendAfter_q <= 1'b1;
          pendSkip_q <= insnDelayedBranch;
          pendUseBr_q <= insnDelayedBranch;
          pendPc_q <= insnAddr;
        end
        else if (pendAfter_q)
          pendSkip_q <= 1'b0;
      end
      // Data hits arrive apart from instructions, set wins
      if (trigData && !pendAfter_q)
      begin
        pendAfter_q <= 1'b1;
        pendSkip_q <= 1'b0;
        pendUseBr_q <= 1'b0;
      end
    end
  end

  // single request held until the exception logic accepts
  // a faulted fetch is never confirmed, so re-execution matches
  // delay slot break taken before its branch
  // before break saves matched or branch address
  // after break saves next or delayed branch address
  // imprecise data break saves the instruction it stops
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      breakReq <= 1'b0;
      breakPc <= 32'h0000_0000;
      insnGrant <= 1'b0;
    end
    else
    begin
      insnGrant <= 1'b0;
      if (breakReq && breakAck)
        breakReq <= 1'b0;
      else if (insnLive && trigBefore)
      begin
        breakReq <= 1'b1;
        breakPc <= insnDelaySlot ? insnBranchAddr : insnAddr;
      end
      else if (insnLive && pendFires)
      begin
        breakReq <= 1'b1;
        breakPc <= pendUseBr_q ? pendPc_q : insnAddr;
      end
      else if (insnLive)
        insnGrant <= 1'b1;
    end
  end
endmodule

// ===== inc/user_break_consts.svh
// Register offsets, field positions and reset values of the user break unit
`ifndef USER_BREAK_CONSTS_SVH
`define USER_BREAK_CONSTS_SVH

// Register byte offsets
`define UB_OFS_A_ADDR 8'h00
`define UB_OFS_A_SPACE 8'h04
`define UB_OFS_A_MASK 8'h08
`define UB_OFS_A_COND 8'h0c
`define UB_OFS_B_ADDR 8'h10
`define UB_OFS_B_SPACE 8'h14
`define UB_OFS_B_MASK 8'h18
`define UB_OFS_B_COND 8'h1c
`define UB_OFS_B_DATA 8'h20
`define UB_OFS_B_DMASK 8'h24
`define UB_OFS_CTRL 8'h28
`define UB_OFS_STATE 8'h2c

// Break control field positions
`define UB_CTRL_FLAG_A 15
`define UB_CTRL_FLAG_B 14
`define UB_CTRL_AFTER_A 10
`define UB_CTRL_DATA_EN 7
`define UB_CTRL_AFTER_B 6
`define UB_CTRL_ORDERED 3
`define UB_CTRL_WMASK 16'hc4c8

// Cycle condition and mask field positions
`define UB_COND_TYPE_HI 5
`define UB_COND_TYPE_LO 4
`define UB_COND_RW_HI 3
`define UB_COND_RW_LO 2
`define UB_COND_SIZE_HI 1
`define UB_COND_SIZE_LO 0
`define UB_MASK_SPACE 2

// Reset values
`define UB_CTRL_RESET 16'h0000
`define UB_COND_RESET 6'h00
`define UB_WORD_RESET 32'h0000_0000

// AXI responses
`define UB_RESP_OKAY 2'h0
`define UB_RESP_SLVERR 2'h2

`endif

// ===== inc/user_break_pkg.sv
// Types shared by the user break unit
package user_break_pkg;

  // Operand size code, also the size of an actual data access
  typedef enum logic [1:0] {
    SIZE_ANY = 2'h0,
    SIZE_BYTE = 2'h1,
    SIZE_WORD = 2'h2,
    SIZE_LONG = 2'h3
  } size_t;

  // Address mask code
  typedef enum logic [1:0] {
    AMASK_NONE = 2'h0,
    AMASK_LOW10 = 2'h1,
    AMASK_LOW12 = 2'h2,
    AMASK_ALL = 2'h3
  } addr_mask_t;

endpackage

// ===== design/axil_reg_port.sv
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/1ns
`include "user_break_consts.svh"
module axil_reg_port
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // AXI4-Lite
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register file side
  output logic wrEn,
  output logic [7:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrErr,
  output logic [7:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);
  logic awHave_q;
  logic wHave_q;
  logic [7:0] awAddr_q;

  assign wrAddr = awAddr_q;
  assign wrEn = awHave_q & wHave_q & ~bvalid;
  assign rdAddr = araddr;

  // Address and data are caught independently, in either order
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHave_q <= 1'b1;
        awAddr_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wHave_q <= 1'b1;
        wrData <= wdata;
        wrStrb <= wstrb;
        wready <= 1'b0;
      end
      if (bvalid && bready)
      begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      bvalid <= 1'b0;
      bresp <= `UB_RESP_OKAY;
    end
    else if (wrEn)
    begin
      bvalid <= 1'b1;
      bresp <= wrErr ? `UB_RESP_SLVERR : `UB_RESP_OKAY;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // Read answered the cycle after the address is taken
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `UB_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdErr ? 32'h0000_0000 : rdData;
      rresp <= rdErr ? `UB_RESP_SLVERR : `UB_RESP_OKAY;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule

// ===== design/break_chan_match.sv
// Address, space, cycle and data comparator for one break channel
`timescale 1ns/1ns
`include "user_break_consts.svh"
module break_chan_match
(
  // Channel settings
  input wire logic [31:0] cfgAddr,
  input wire logic [7:0] cfgSpace,
  input wire logic [2:0] cfgMask,
  input wire logic [5:0] cfgCond,
  input wire logic cfgDataEn,
  input wire logic [31:0] cfgData,
  input wire logic [31:0] cfgDataMask,
  // Confirmed instruction
  input wire logic insnValid,
  input wire logic [31:0] insnAddr,
  input wire logic [7:0] insnSpace,
  // Data access cycle
  input wire logic cycValid,
  input wire logic [31:0] cycAddr,
  input wire logic [7:0] cycSpace,
  input wire logic cycWrite,
  input wire logic [1:0] cycSize,
  input wire logic [31:0] cycData,
  // Hits
  output logic fetchHit,
  output logic dataHit
);
  logic [1:0] cType;
  logic [1:0] cRw;
  logic [1:0] cSize;
  logic chanOn;
  logic [31:0] aMask;
  logic [1:0] effSize;
  logic [31:0] sizeMask;
  logic [31:0] dMask;
  logic spaceFetch;
  logic spaceData;
  logic rwData;
  logic dataOk;

  assign cType = cfgCond[`UB_COND_TYPE_HI:`UB_COND_TYPE_LO];
  assign cRw = cfgCond[`UB_COND_RW_HI:`UB_COND_RW_LO];
  assign cSize = cfgCond[`UB_COND_SIZE_HI:`UB_COND_SIZE_LO];
  assign chanOn = (cType != 2'h0) || (cRw != 2'h0);
  assign spaceFetch = cfgMask[`UB_MASK_SPACE] || (insnSpace == cfgSpace);
  assign spaceData = cfgMask[`UB_MASK_SPACE] || (cycSpace == cfgSpace);

  always_comb
  begin
    unique case (user_break_pkg::addr_mask_t'(cfgMask[1:0]))
      user_break_pkg::AMASK_NONE: aMask = 32'hffff_ffff;
      user_break_pkg::AMASK_LOW10: aMask = 32'hffff_fc00;
      user_break_pkg::AMASK_LOW12: aMask = 32'hffff_f000;
      user_break_pkg::AMASK_ALL: aMask = 32'h0000_0000;
    endcase
  end

  assign effSize = (cSize == 2'h0) ? cycSize : cSize;
  always_comb
  begin
    unique case (user_break_pkg::size_t'(effSize))
      user_break_pkg::SIZE_WORD: sizeMask = 32'hffff_fffe;
      user_break_pkg::SIZE_LONG: sizeMask = 32'hffff_fffc;
      default: sizeMask = 32'hffff_ffff;
    endcase
  end

  // upper half ignored for byte and word
  assign dMask = (effSize == 2'h3) ? ~cfgDataMask : {16'h0000, ~cfgDataMask[15:0]};
  assign dataOk = !cfgDataEn || (((cycData ^ cfgData) & dMask) == 32'h0000_0000);
  assign rwData = (cRw == 2'h0) || (cycWrite ? cRw[1] : cRw[0]);

  // each instruction by its own start address
  // fetch match never looks at data compare
  assign fetchHit = insnValid && chanOn && (cType != 2'h2) && (cRw != 2'h2)
    && ((cSize == 2'h0) || (cSize == 2'h2)) && spaceFetch
    && (((insnAddr ^ cfgAddr) & aMask) == 32'h0000_0000);
  assign dataHit = cycValid && chanOn && (cType != 2'h1) && rwData && spaceData
    && ((cSize == 2'h0) || (cSize == cycSize)) && dataOk
    && (((cycAddr ^ cfgAddr) & aMask & sizeMask) == 32'h0000_0000);
endmodule

// ===== bench/user_break_match_unit_sva.sv
// Port checker for the user break unit
`timescale 1ns/1ns
module user_break_sva
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Exception side
  input wire logic insnValid,
  input wire logic insnGrant,
  input wire logic breakReq,
  input wire logic [31:0] breakPc,
  input wire logic breakAck,
  // Register port
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  property p_answer;
    insnValid && !breakReq |=> insnGrant != breakReq;
  endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_quiet;
    !insnValid || breakReq |=> !insnGrant;
  endproperty
  a_quiet: assert property (p_quiet) else $error("grant without insn");
  property p_rise;
    $rose(breakReq) |-> $past(insnValid);
  endproperty
  a_rise: assert property (p_rise) else $error("break without insn");
  property p_hold;
    breakReq && !breakAck |=> breakReq && $stable(breakPc);
  endproperty
  a_hold: assert property (p_hold) else $error("break dropped early");
  property p_drop;
    breakReq && breakAck |=> !breakReq;
  endproperty
  a_drop: assert property (p_drop) else $error("break kept after accept");
  property p_rHold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("read data moved");
  property p_bHold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("write response moved");
  property p_rAns;
    arvalid && arready |-> ##1 rvalid;
  endproperty
  a_rAns: assert property (p_rAns) else $error("read not answered");
  // Main scenarios seen
  c_break: cover property ($rose(breakReq));
  c_grant: cover property (insnGrant);
  c_slverr: cover property (bvalid && bresp == 2'h2);
endmodule
bind user_break_match_unit user_break_sva u_user_break_sva (.clk_sys, .nrst, .insnValid, .insnGrant,
  .breakReq, .breakPc, .breakAck, .arvalid, .arready, .rvalid, .rready, .rdata, .bvalid, .bready, .bresp);

// ===== bench/cpu_pipe_model.sv
// Pipeline and exception logic model facing the user break unit
`timescale 1ns/1ns
module cpu_pipe_model
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Confirmed instruction
  output logic insnValid = 1'h0,
  output logic [31:0] insnAddr = 32'h0,
  output logic [7:0] insnSpace = 8'h0,
  output logic insnDelaySlot = 1'h0,
  output logic insnDelayedBranch = 1'h0,
  output logic [31:0] insnBranchAddr = 32'h0,
  // Exception side
  input wire logic insnGrant,
  input wire logic breakReq,
  input wire logic [31:0] breakPc,
  output logic breakAck = 1'h0
);
  // Cycles before a break is accepted; slow exception logic
  int ackWait = 0;
  // ----
  // Instruction issue
  // ----
  // only confirmed insns
  task automatic issue(input logic [31:0] a, input logic ds, db, input logic [31:0] ba,
    output logic brk, output logic gnt, output logic [31:0] pc);
    @(posedge clk_sys);
    insnValid <= 1'h1;
    insnAddr <= a;
    insnDelaySlot <= ds;
    insnDelayedBranch <= db;
    insnBranchAddr <= ba;
    @(posedge clk_sys);
    // Released lines carry junk so stale values never match
    insnValid <= 1'h0;
    insnAddr <= ~a;
    insnBranchAddr <= ~ba;
    // Answer stands at the edge after the take
    @(posedge clk_sys);
    brk = breakReq;
    gnt = insnGrant;
    pc = breakPc;
    if (brk)
    begin
      repeat (ackWait) @(posedge clk_sys);
      breakAck <= 1'h1;
      @(posedge clk_sys);
      breakAck <= 1'h0;
    end
  endtask
endmodule

// ===== bench/user_break_match_unit_tb_top.sv
// Self-checking bench for the user break unit
`timescale 1ns/1ns
`include "user_break_consts.svh"
`define CHK(n, e, a) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      miscompares++; \
      $display("unexpected %s exp %h got %h", n, e, a); \
    end \
  end
module user_break_match_unit_tb_top;
  logic clk_sys, nrst = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, cycValid = 1'h0, cycWrite = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, insnValid, insnDelaySlot;
  logic insnDelayedBranch, insnGrant, breakReq, breakAck, brk, gnt;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, cycSpace = 8'h0, insnSpace;
  logic [31:0] wdata = 32'h0, cycAddr = 32'h0, cycData = 32'h0;
  logic [31:0] rdata, insnAddr, insnBranchAddr, breakPc, rv, pc;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] cycSize = 2'h0, bresp, rresp, rr, br;
  logic [31:0] hitA [4] = '{32'h1000, 32'h13fe, 32'h1ffe, 32'h8000};
  logic [31:0] missA [3] = '{32'h1002, 32'h1400, 32'h2000};
  int miscompares = 0;
  int comparisons = 0;
  user_break_match_unit u_user_break_match_unit (.*);
  cpu_pipe_model u_cpu_pipe_model (.*);
  // 100 MHz clock
  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ----
  // Bus and pipeline tasks
  // ----
  task automatic finish_test();
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // A wait that runs out ends the run
  task automatic hang();
    miscompares++;
    finish_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid)
      begin
        br = bresp;
        bready <= 1'h0;
        return;
      end
    end
    hang();
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'h0;
      if (rvalid)
      begin
        rv = rdata;
        rr = rresp;
        rready <= 1'h0;
        return;
      end
    end
    hang();
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK("register", e, rv)
  endtask
  task automatic ex(input logic [31:0] a, input logic ds, db, input logic [31:0] ba,
    input logic eb, input logic [31:0] ep);
    u_cpu_pipe_model.issue(a, ds, db, ba, brk, gnt, pc);
    `CHK("breakReq", eb, brk)
    `CHK("insnGrant", !eb, gnt)
    if (eb)
      `CHK("breakPc", ep, pc)
  endtask
  // One data access pulse; data lines go to junk after it
  task automatic acc(input logic [31:0] a, input logic [1:0] s, input logic [31:0] d);
    @(posedge clk_sys);
    cycValid <= 1'h1;
    cycWrite <= 1'h1;
    cycAddr <= a;
    cycSize <= s;
    cycData <= d;
    @(posedge clk_sys);
    cycValid <= 1'h0;
    cycData <= ~d;
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'h1;
    rchk(`UB_OFS_CTRL, 32'h0);
    rchk(8'h30, 32'h0);
    `CHK("rresp", `UB_RESP_SLVERR, rr)
    wr(8'h30, 32'h1);
    `CHK("bresp", `UB_RESP_SLVERR, br)
    // Reserved bits drop, flags ignore a written one
    wr(`UB_OFS_CTRL, 32'hffff);
    rchk(`UB_OFS_CTRL, 32'h4c8);
    wr(`UB_OFS_CTRL, 32'h0);
    wr(`UB_OFS_A_ADDR, 32'h1000);
    ex(32'h1000, 1'h0, 1'h0, 32'h0, 1'h0, 32'h0);
    // Conditions armed last, then each mask code
    wr(`UB_OFS_A_COND, 32'h16);
    for (int i = 0; i < 4; i++)
    begin
      wr(`UB_OFS_A_MASK, 32'(i));
      ex(hitA[i], 1'h0, 1'h0, 32'h0, 1'h1, hitA[i]);
      if (i < 3)
        ex(missA[i], 1'h0, 1'h0, 32'h0, 1'h0, 32'h0);
    end
    rchk(`UB_OFS_CTRL, 32'h8000);
    // Writing one to a set flag keeps it
    wr(`UB_OFS_CTRL, 32'h8000);
    rchk(`UB_OFS_CTRL, 32'h8000);
    wr(`UB_OFS_CTRL, 32'h0);
    rchk(`UB_OFS_CTRL, 32'h0);
    wr(`UB_OFS_A_MASK, 32'h0);
    // After-execution break, plain and on a delayed branch
    wr(`UB_OFS_CTRL, 32'h400);
    ex(32'h1000, 1'h0, 1'h0, 32'h0, 1'h0, 32'h0);
    u_cpu_pipe_model.ackWait = 4;
    ex(32'h1010, 1'h0, 1'h0, 32'h0, 1'h1, 32'h1010);
    u_cpu_pipe_model.ackWait = 0;
    ex(32'h1000, 1'h0, 1'h1, 32'h0, 1'h0, 32'h0);
    ex(32'h1002, 1'h1, 1'h0, 32'h1000, 1'h0, 32'h0);
    ex(32'h3000, 1'h0, 1'h0, 32'h0, 1'h1, 32'h1000);
    // Before break on a delay slot lands on its branch
    wr(`UB_OFS_CTRL, 32'h0);
    ex(32'h1000, 1'h1, 1'h0, 32'h0ffe, 1'h1, 32'h0ffe);
    // Ordered mode: B alone, then A, then B
    wr(`UB_OFS_B_ADDR, 32'h3000);
    wr(`UB_OFS_B_COND, 32'h16);
    wr(`UB_OFS_CTRL, 32'h88);
    ex(32'h3000, 1'h0, 1'h0, 32'h0, 1'h0, 32'h0);
    ex(32'h1000, 1'h0, 1'h0, 32'h0, 1'h0, 32'h0);
    ex(32'h3000, 1'h0, 1'h0, 32'h0, 1'h1, 32'h3000);
    rchk(`UB_OFS_CTRL, 32'h4088);
    // Data break with address and word data
    wr(`UB_OFS_A_COND, 32'h0);
    wr(`UB_OFS_B_ADDR, 32'h4002);
    wr(`UB_OFS_B_DATA, 32'h5a5aa512);
    wr(`UB_OFS_B_DMASK, 32'h0);
    wr(`UB_OFS_B_COND, 32'h2a);
    wr(`UB_OFS_CTRL, 32'h80);
    acc(32'h4002, 2'h2, 32'ha512);
    ex(32'h5000, 1'h0, 1'h0, 32'h0, 1'h1, 32'h5000);
    acc(32'h4002, 2'h2, 32'ha513);
    ex(32'h5000, 1'h0, 1'h0, 32'h0, 1'h0, 32'h0);
    // Size code 00 follows the access size
    wr(`UB_OFS_B_COND, 32'h28);
    wr(`UB_OFS_CTRL, 32'h0);
    acc(32'h4000, 2'h3, 32'h0);
    ex(32'h6000, 1'h0, 1'h0, 32'h0, 1'h1, 32'h6000);
    acc(32'h4000, 2'h2, 32'h0);
    ex(32'h6000, 1'h0, 1'h0, 32'h0, 1'h0, 32'h0);
    // Second reset in mid-run
    wr(`UB_OFS_CTRL, 32'h8);
    @(posedge clk_sys);
    nrst <= 1'h0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'h1;
    rchk(`UB_OFS_CTRL, 32'h0);
    rchk(`UB_OFS_B_COND, 32'h0);
    finish_test();
  end
endmodule
